// ### gige_pcs_pkg.sv
// Constants shared by the compatible receive path
package gige_pcs_pkg;
  localparam int LINK_PERIOD_NS = 160;
  localparam int CORE_PERIOD_NS = 20;
  localparam int GROUP_CYCLES = LINK_PERIOD_NS / CORE_PERIOD_NS;
  localparam logic [2:0] HALF_CYCLES = 3'(GROUP_CYCLES / 2);
  localparam logic [2:0] COMMA_LOCK_COUNT = 3'h4;
  localparam logic [1:0] SYNC_ACQ_COUNT = 2'h3;
  localparam logic [2:0] SYNC_LOSS_COUNT = 3'h4;
  localparam logic [7:0] PREAMBLE = 8'h55;
  localparam logic [9:0] K285_NEG = 10'h0FA;
  localparam logic [9:0] K285_POS = 10'h305;
  localparam logic [9:0] K277_NEG = 10'h368;
  localparam logic [9:0] K277_POS = 10'h097;
  localparam logic [9:0] K297_NEG = 10'h2E8;
  localparam logic [9:0] K297_POS = 10'h117;
  localparam logic [6:0] COMMA_NEG = 7'h1F;
  localparam logic [6:0] COMMA_POS = 7'h60;
  localparam logic [5:0] K28_NEG6 = 6'h0F;
  localparam logic [5:0] K28_POS6 = 6'h30;
  localparam int CFG_TBI = 0;
  localparam int CFG_STDPHY = 1;
  localparam int CFG_SYNCMODE = 2;
  localparam int CFG_CDET = 3;
  localparam int CFG_REFLOCK = 4;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_REALIGN_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int ST_BYTE_BIT = 0;
  localparam int ST_TBI_BIT = 1;
  localparam int ST_BYTEAL_BIT = 2;
  localparam int ST_SYNC_BIT = 3;
  localparam int ST_EOAL_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### code_group_decoder.sv
// Ten-bit code group decoder with control and error flags
`timescale 1ns/100ps
module code_group_decoder (
  input wire logic [9:0] codeGroup,
  output logic [7:0] dataByte,
  output logic isCtrl,
  output logic isIdle,
  output logic isSop,
  output logic isEop,
  output logic hasComma,
  output logic isBad
);
  import gige_pcs_pkg::*;
  logic [4:0] low;
  logic [2:0] high;
  logic lowOk;
  logic highOk;
  always_comb
  begin
    lowOk = 1'b1;
    highOk = 1'b1;
    high = 3'h0;
    case (codeGroup[9:4])
      6'b100111, 6'b011000: low = 5'h00;
      6'b011101, 6'b100010: low = 5'h01;
      6'b101101, 6'b010010: low = 5'h02;
      6'b110001: low = 5'h03;
      6'b110101, 6'b001010: low = 5'h04;
      6'b101001: low = 5'h05;
      6'b011001: low = 5'h06;
      6'b111000, 6'b000111: low = 5'h07;
      6'b111001, 6'b000110: low = 5'h08;
      6'b100101: low = 5'h09;
      6'b010101: low = 5'h0A;
      6'b110100: low = 5'h0B;
      6'b001101: low = 5'h0C;
      6'b101100: low = 5'h0D;
      6'b011100: low = 5'h0E;
      6'b010111, 6'b101000: low = 5'h0F;
      6'b011011, 6'b100100: low = 5'h10;
      6'b100011: low = 5'h11;
      6'b010011: low = 5'h12;
      6'b110010: low = 5'h13;
      6'b001011: low = 5'h14;
      6'b101010: low = 5'h15;
      6'b011010: low = 5'h16;
      6'b111010, 6'b000101: low = 5'h17;
      6'b110011, 6'b001100: low = 5'h18;
      6'b100110: low = 5'h19;
      6'b010110: low = 5'h1A;
      6'b110110, 6'b001001: low = 5'h1B;
      6'b001110, 6'b001111, 6'b110000: low = 5'h1C;
      6'b101110, 6'b010001: low = 5'h1D;
      6'b011110, 6'b100001: low = 5'h1E;
      6'b101011, 6'b010100: low = 5'h1F;
      default:
      begin
        low = 5'h00;
        lowOk = 1'b0;
      end
    endcase
    case (codeGroup[3:0])
      4'b1011, 4'b0100: high = 3'h0;
      4'b1001: high = 3'h1;
      4'b0101: high = 3'h2;
      4'b1100, 4'b0011: high = 3'h3;
      4'b1101, 4'b0010: high = 3'h4;
      4'b1010: high = 3'h5;
      4'b0110: high = 3'h6;
      4'b1110, 4'b0001, 4'b0111, 4'b1000: high = 3'h7;
      default: highOk = 1'b0;
    endcase
    dataByte = {high, low};
    isIdle = codeGroup == K285_NEG || codeGroup == K285_POS;
    isSop = codeGroup == K277_NEG || codeGroup == K277_POS;
    isEop = codeGroup == K297_NEG || codeGroup == K297_POS;
    hasComma = codeGroup[9:3] == COMMA_NEG || codeGroup[9:3] == COMMA_POS;
    isCtrl = codeGroup[9:4] == K28_NEG6 || codeGroup[9:4] == K28_POS6 || isSop || isEop;
    isBad = !lowOk || !highOk;
  end
endmodule

// ### gige_standard_phy_sel_pcs_interface.sv
// Compatible byte and ten-bit receive alignment with transmit capture
`timescale 1ns/100ps
module gige_standard_phy_sel_pcs_interface (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tenBitIfaceSel,
  input wire logic standardPhySel,
  input wire logic synchronizedModeSel,
  input wire logic recoveredClockSel,
  input wire logic txControlCharOrCommaEnable,
  input wire logic txChannelClock,
  input wire logic txChannelEnable,
  input wire logic txChannelForceError,
  input wire logic [7:0] txChannelData,
  input wire logic rxLinkClock,
  input wire logic [9:0] rxLinkWord,
  output logic rxChannelClock,
  output logic rxChannelClockSecondPhase,
  output logic [7:0] rxChannelData,
  output logic rxChannelError,
  output logic rxChannelDataValid,
  output logic rxCommaDetected,
  output logic rxExtraErrorFlag,
  output logic [9:0] txCodeWord,
  output logic txCodeIsTenBit,
  output logic txCodeStrobe,
  input wire logic [gige_pcs_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [gige_pcs_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import gige_pcs_pkg::*;

  typedef struct packed {
    logic lclkS1;
    logic lclkS2;
    logic lclkD;
    logic [9:0] rawS1;
    logic [9:0] rawS2;
    logic [4:0] cfgS1;
    logic [4:0] cfgS2;
    logic tclkS1;
    logic tclkS2;
    logic tclkD;
    logic [9:0] txS1;
    logic [9:0] txS2;
    logic [9:0] prevRaw;
    logic [3:0] off;
    logic [2:0] commaCnt;
    logic byteAl;
    logic streamSync;
    logic [1:0] syncCnt;
    logic [2:0] badCnt;
    logic expectData;
    logic eoAl;
    logic outEven;
    logic delayed;
    logic [9:0] lastGrp;
    logic [9:0] lastOut;
    logic inPkt;
    logic pktErr;
    logic [2:0] halfCnt;
    logic rxClkA;
    logic rxClkB;
    logic [7:0] rxData;
    logic rxErr;
    logic rxDv;
    logic rxComma;
    logic rxExtra;
    logic [9:0] txCode;
    logic txTen;
    logic txStrobe;
    logic ctrlEn;
    logic realign;
    logic awRdy;
    logic wRdy;
    logic awHeld;
    logic wHeld;
    logic [7:0] wAddr;
    logic [7:0] wData;
    logic wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } state_t;

  state_t s;
  state_t n;
  logic [19:0] win;
  logic [9:0] grp;
  logic [9:0] cand;
  logic cFound;
  logic [3:0] cOff;
  logic [7:0] dByte;
  logic dCtrl;
  logic dIdle;
  logic dSop;
  logic dEop;
  logic dComma;
  logic dBad;
  logic byteMode;
  logic tbiMode;
  logic commaEn;
  logic grpStrobe;
  logic txStrobeIn;
  logic hold;
  logic firstIdle;
  logic curEven;
  logic repeatNow;

  // Comma search over the ten bit offsets starting in the older of the last two words
  always_comb
  begin
    win = {s.prevRaw, s.rawS2};
    cFound = 1'b0;
    cOff = 4'h0;
    for (int k = 0; k < 10; k++)
    begin
      if (!cFound && (win[19-k -: 7] == COMMA_NEG || win[19-k -: 7] == COMMA_POS))
      begin
        cFound = 1'b1;
        cOff = 4'(k);
      end
    end
    grp = win[5'd19 - {1'b0, s.off} -: 10];
    cand = s.delayed ? s.lastGrp : grp;
  end

  code_group_decoder code_group_decoder_i (
    .codeGroup(cand),
    .dataByte(dByte),
    .isCtrl(dCtrl),
    .isIdle(dIdle),
    .isSop(dSop),
    .isEop(dEop),
    .hasComma(dComma),
    .isBad(dBad)
  );

  assign byteMode = !s.cfgS2[CFG_TBI] && s.cfgS2[CFG_STDPHY] && s.cfgS2[CFG_SYNCMODE];
  assign tbiMode = s.cfgS2[CFG_TBI] && s.cfgS2[CFG_STDPHY] && s.cfgS2[CFG_SYNCMODE];
  assign commaEn = s.cfgS2[CFG_CDET];
  assign grpStrobe = s.lclkS2 && !s.lclkD;
  assign txStrobeIn = s.tclkS2 && !s.tclkD;
  // Lock to reference in ten-bit mode parks the receiver
  assign hold = !(byteMode || tbiMode) || !s.ctrlEn || s.realign
    || (tbiMode && s.cfgS2[CFG_REFLOCK]);
  assign firstIdle = tbiMode && !s.eoAl && dIdle;
  assign curEven = firstIdle || s.outEven;
  assign repeatNow = tbiMode && s.eoAl && commaEn && dIdle && !s.outEven && !s.delayed;

  always_comb
  begin
    n = s;
    n.lclkS1 = rxLinkClock;
    n.lclkS2 = s.lclkS1;
    n.lclkD = s.lclkS2;
    n.rawS1 = rxLinkWord;
    n.rawS2 = s.rawS1;
    n.cfgS1 = {recoveredClockSel, txControlCharOrCommaEnable, synchronizedModeSel,
      standardPhySel, tenBitIfaceSel};
    n.cfgS2 = s.cfgS1;
    n.tclkS1 = txChannelClock;
    n.tclkS2 = s.tclkS1;
    n.tclkD = s.tclkS2;
    n.txS1 = {txChannelForceError, txChannelEnable, txChannelData};
    n.txS2 = s.txS1;
    n.realign = 1'b0;
    n.txStrobe = 1'b0;
    // Transmit capture; the control-character input never reaches the code word
    if (txStrobeIn && (byteMode || tbiMode))
    begin
      n.txCode = s.txS2;
      if (tbiMode)
      begin
        n.txCode = {<<{s.txS2}};
      end
      n.txTen = tbiMode;
      n.txStrobe = 1'b1;
    end
    // Byte-mode receive clock rises half a group after the data change
    if (byteMode && !s.rxClkA)
    begin
      n.halfCnt = s.halfCnt + 3'h1;
      if (s.halfCnt == HALF_CYCLES - 3'h1)
      begin
        n.rxClkA = 1'b1;
      end
    end
    if (grpStrobe)
    begin
      n.prevRaw = s.rawS2;
      n.rxClkA = 1'b0;
      n.halfCnt = 3'h0;
      if (tbiMode)
      begin
        // Aligned on the first comma; later commas move the offset only when enabled
        if (cFound && (!s.byteAl || (commaEn && cOff != s.off)))
        begin
          n.off = cOff;
          n.byteAl = 1'b1;
        end
      end
      else if (cFound && !s.byteAl)
      begin
        n.off = cOff;
        n.commaCnt = (cOff == s.off) ? s.commaCnt + 3'h1 : 3'h1;
        n.byteAl = n.commaCnt == COMMA_LOCK_COUNT;
      end
      if (byteMode && s.byteAl)
      begin
        n.badCnt = dBad ? s.badCnt + 3'h1 : 3'h0;
        n.expectData = dIdle;
        if (dBad)
        begin
          n.syncCnt = 2'h0;
        end
        else if (!s.streamSync && s.expectData && !dCtrl)
        begin
          n.syncCnt = s.syncCnt + 2'h1;
        end
        if (n.syncCnt == SYNC_ACQ_COUNT)
        begin
          n.streamSync = 1'b1;
        end
        if (n.badCnt == SYNC_LOSS_COUNT)
        begin
          n.streamSync = 1'b0;
          n.byteAl = 1'b0;
          n.commaCnt = 3'h0;
          n.syncCnt = 2'h0;
          n.badCnt = 3'h0;
        end
      end
      if (byteMode)
      begin
        n.pktErr = 1'b0;
        if (!(s.byteAl && s.streamSync))
        begin
          n.inPkt = 1'b0;
          n.rxDv = 1'b0;
          n.rxData = 8'h00;
        end
        else if (dSop)
        begin
          n.rxData = PREAMBLE;
          n.rxDv = 1'b1;
          n.inPkt = 1'b1;
        end
        else if (s.inPkt && dEop)
        begin
          // Last data byte went out on the previous group
          n.rxDv = 1'b0;
          n.inPkt = 1'b0;
          n.rxData = 8'h00;
        end
        else if (s.inPkt)
        begin
          n.rxData = dByte;
          n.pktErr = dBad;
        end
        else
        begin
          n.rxData = 8'h00;
        end
      end
      else if (tbiMode)
      begin
        n.lastGrp = grp;
        n.eoAl = s.eoAl || firstIdle;
        n.outEven = !curEven;
        n.rxClkB = curEven;
        n.rxClkA = !curEven;
        if (repeatNow)
        begin
          n.delayed = 1'b1;
          {n.rxErr, n.rxDv, n.rxData} = {<<{s.lastOut}};
          n.rxComma = 1'b0;
          n.rxExtra = 1'b0;
        end
        else
        begin
          n.lastOut = cand;
          {n.rxErr, n.rxDv, n.rxData} = {<<{cand}};
          n.rxComma = dComma;
          n.rxExtra = dBad;
        end
      end
    end
    if (hold)
    begin
      n.byteAl = 1'b0;
      n.streamSync = 1'b0;
      n.commaCnt = 3'h0;
      n.syncCnt = 2'h0;
      n.badCnt = 3'h0;
      n.expectData = 1'b0;
      n.eoAl = 1'b0;
      n.delayed = 1'b0;
      n.inPkt = 1'b0;
      n.pktErr = 1'b0;
      n.rxDv = 1'b0;
      n.rxComma = 1'b0;
      n.rxExtra = 1'b0;
    end
    if (byteMode)
    begin
      n.rxErr = !(n.byteAl && n.streamSync) || n.pktErr;
      n.rxClkB = 1'b0;
      n.rxComma = 1'b0;
      n.rxExtra = 1'b0;
    end
    else if (!tbiMode)
    begin
      n.rxData = 8'h00;
      n.rxErr = 1'b0;
      n.rxClkA = 1'b0;
      n.rxClkB = 1'b0;
    end
    // Register slave
    if (s.bValid && bready)
    begin
      n.bValid = 1'b0;
    end
    if (awvalid && s.awRdy)
    begin
      n.awHeld = 1'b1;
      n.wAddr = awaddr;
    end
    if (wvalid && s.wRdy)
    begin
      n.wHeld = 1'b1;
      n.wData = wdata[7:0];
      n.wStrb = wstrb[0];
    end
    if (s.awHeld && s.wHeld && !s.bValid)
    begin
      n.awHeld = 1'b0;
      n.wHeld = 1'b0;
      n.bValid = 1'b1;
      n.bResp = RESP_OKAY;
      if (s.wAddr == CTRL_OFS)
      begin
        if (s.wStrb)
        begin
          n.ctrlEn = s.wData[CTRL_EN_BIT];
          n.realign = s.wData[CTRL_REALIGN_BIT];
        end
      end
      else if (s.wAddr != STATUS_OFS)
      begin
        n.bResp = RESP_SLVERR;
      end
    end
    n.awRdy = !n.awHeld && !n.bValid;
    n.wRdy = !n.wHeld && !n.bValid;
    if (s.rValid && rready)
    begin
      n.rValid = 1'b0;
    end
    if (arvalid && s.arRdy)
    begin
      n.rValid = 1'b1;
      n.rData = 32'h0000_0000;
      n.rResp = RESP_OKAY;
      if (araddr == CTRL_OFS)
      begin
        n.rData[CTRL_EN_BIT] = s.ctrlEn;
      end
      else if (araddr == STATUS_OFS)
      begin
        n.rData[ST_BYTE_BIT] = byteMode;
        n.rData[ST_TBI_BIT] = tbiMode;
        n.rData[ST_BYTEAL_BIT] = s.byteAl;
        n.rData[ST_SYNC_BIT] = s.streamSync;
        n.rData[ST_EOAL_BIT] = s.eoAl;
      end
      else
      begin
        n.rResp = RESP_SLVERR;
      end
    end
    n.arRdy = !n.rValid;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.ctrlEn <= CTRL_EN_RESET;
    end
    else
    begin
      s <= n;
    end
  end

  assign rxChannelClock = s.rxClkA;
  assign rxChannelClockSecondPhase = s.rxClkB;
  assign rxChannelData = s.rxData;
  assign rxChannelError = s.rxErr;
  assign rxChannelDataValid = s.rxDv;
  assign rxCommaDetected = s.rxComma;
  assign rxExtraErrorFlag = s.rxExtra;
  assign txCodeWord = s.txCode;
  assign txCodeIsTenBit = s.txTen;
  assign txCodeStrobe = s.txStrobe;
  assign awready = s.awRdy;
  assign wready = s.wRdy;
  assign bvalid = s.bValid;
  assign bresp = s.bResp;
  assign arready = s.arRdy;
  assign rvalid = s.rValid;
  assign rdata = s.rData;
  assign rresp = s.rResp;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence syncedGroup;
    grpStrobe && byteMode && s.byteAl && s.streamSync && !hold;
  endsequence

  sequence sopGroup;
    syncedGroup ##0 dSop;
  endsequence

  errUntilSync_a:
    assert property (byteMode && $past(byteMode) && !(s.byteAl && s.streamSync)
      |-> rxChannelError)
    else $error("receive error low before alignment");
  preambleOut_a:
    assert property (sopGroup |=> rxChannelDataValid && rxChannelData == PREAMBLE)
    else $error("start of packet not replaced by preamble");
  eopDrop_a:
    assert property (syncedGroup ##0 (s.inPkt && dEop && !dSop)
      |=> !rxChannelDataValid [*2])
    else $error("data valid not dropped at end of packet");
  dvSteady_a:
    assert property (byteMode && !grpStrobe && !hold |=> $stable(rxChannelDataValid))
    else $error("data valid changed between groups");
  lastData_a:
    assert property (syncedGroup ##0 (s.inPkt && !dSop && !dEop && !dBad)
      |=> rxChannelDataValid && rxChannelData == $past(dByte))
    else $error("packet data byte lost");
  fourCommas_a:
    assert property ($rose(s.byteAl) && $past(byteMode) |-> s.commaCnt == COMMA_LOCK_COUNT)
    else $error("byte alignment without four commas");
  streamAcq_a:
    assert property ($rose(s.streamSync) |-> s.byteAl && s.syncCnt == SYNC_ACQ_COUNT)
    else $error("stream sync without byte alignment");
  commaFlag_a:
    assert property (grpStrobe && tbiMode && !hold && !repeatNow && dComma
      |=> rxCommaDetected)
    else $error("comma not flagged");
  idleOnB_a:
    assert property (grpStrobe && firstIdle && !hold
      |=> rxChannelClockSecondPhase && !rxChannelClock)
    else $error("first idle not on second phase clock");
  noRealign_a:
    assert property (grpStrobe && tbiMode && !hold && s.byteAl && !commaEn |=> $stable(s.off))
    else $error("realigned with comma detect disabled");
  repeatData_a:
    assert property (grpStrobe && repeatNow && !hold
      |=> $stable(rxChannelData) && !rxChannelClockSecondPhase)
    else $error("odd idle not preceded by repeated group");
  txTenBit_a:
    assert property (txStrobeIn && tbiMode |=> txCodeStrobe && txCodeIsTenBit)
    else $error("ten-bit transmit word not captured");
endmodule

// ### mac_model.sv
// Far-side model: link code group source and MAC transmit driver
`timescale 1ns/100ps
module mac_model (
  output logic rxLinkClock,
  output logic [9:0] rxLinkWord,
  output logic txChannelClock,
  output logic txChannelEnable,
  output logic txChannelForceError,
  output logic [7:0] txChannelData
);
  import gige_pcs_pkg::*;
  logic [9:0] q[$];
  logic ph = 1'h0;
  initial
  begin
    rxLinkClock = 1'h0;
    txChannelClock = 1'h0;
    rxLinkWord = K285_NEG;
    txChannelEnable = 1'h0;
    txChannelForceError = 1'h0;
    txChannelData = 8'h00;
  end
  initial
  begin
    #3;
    forever #80 rxLinkClock = !rxLinkClock;
  end
  initial
  begin
    #7;
    forever #80 txChannelClock = !txChannelClock;
  end
  // Idle pairs fill gaps; queued groups go out after a full pair
  always @(negedge rxLinkClock)
  begin
    if (q.size() > 0 && !ph)
      rxLinkWord <= q.pop_front();
    else
    begin
      rxLinkWord <= ph ? 10'h245 : K285_NEG;
      ph <= !ph;
    end
  end
  task automatic put(input logic [9:0] g);
    q.push_back(g);
  endtask
  // Transmit inputs change on the falling transmit clock edge
  task automatic macTx(input logic e, input logic r, input logic [7:0] d);
    @(negedge txChannelClock);
    txChannelEnable = e;
    txChannelForceError = r;
    txChannelData = d;
    @(posedge txChannelClock);
  endtask
endmodule

// ### test_gige_standard_phy_sel_pcs_interface.sv
// Self-checking bench for the compatible byte and ten-bit interface
`timescale 1ns/100ps
module test_gige_standard_phy_sel_pcs_interface;
  import gige_pcs_pkg::*;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic tenBitIfaceSel = 1'h0;
  logic standardPhySel = 1'h1;
  logic synchronizedModeSel = 1'h1;
  logic recoveredClockSel = 1'h0;
  logic txControlCharOrCommaEnable = 1'h0;
  logic txChannelClock, txChannelEnable, txChannelForceError, rxLinkClock;
  logic [7:0] txChannelData;
  logic [9:0] rxLinkWord, txCodeWord;
  logic rxChannelClock, rxChannelClockSecondPhase, rxChannelError, rxChannelDataValid;
  logic rxCommaDetected, rxExtraErrorFlag, txCodeIsTenBit, txCodeStrobe;
  logic [7:0] rxChannelData;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0] pkt[$];
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  always #10 core_clk = !core_clk;
  gige_standard_phy_sel_pcs_interface gige_standard_phy_sel_pcs_interface_i (.*);
  mac_model mac_model_i (.*);
  always @(posedge rxChannelClock)
    if (rxChannelDataValid && !tenBitIfaceSel)
      pkt.push_back(rxChannelData);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      error_cnt++;
      final_report();
    end
  end
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (arready)
        arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic setMode(input logic tbi);
    @(posedge core_clk);
    nrst <= 1'h0;
    tenBitIfaceSel <= tbi;
    repeat (8) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic txCheck(input logic e, input logic r, input logic [7:0] d, input logic [9:0] w);
    mac_model_i.macTx(e, r, d);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (!txCodeStrobe && n < 40);
    check(txCodeWord, w);
  endtask
  task automatic waitFlag(input int which);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (!(which ? rxExtraErrorFlag : rxCommaDetected) && n < 400);
    check(which ? rxExtraErrorFlag : rxCommaDetected, 1'h1);
  endtask
  initial
  begin
    setMode(1'h0);
    check(rxChannelError, 1'h1);
    axiRd(CTRL_OFS, rd, resp);
    check(rd, 32'h1);
    repeat (GROUP_CYCLES * 40) @(posedge core_clk);
    axiRd(STATUS_OFS, rd, resp);
    check(rd & 32'hF, 32'hD);
    check(rxChannelError, 1'h0);
    mac_model_i.put(K277_NEG);
    repeat (3) mac_model_i.put(10'h2AA);
    mac_model_i.put(K297_NEG);
    repeat (GROUP_CYCLES * 24) @(posedge core_clk);
    check(pkt.size(), 4);
    check(pkt[0], PREAMBLE);
    for (int i = 1; i < 4; i++)
      check(pkt[i], 8'hB5);
    check(rxChannelDataValid, 1'h0);
    txCheck(1'h1, 1'h0, 8'hA5, 10'h1A5);
    txCheck(1'h1, 1'h1, 8'h3C, 10'h33C);
    axiWr(CTRL_OFS, 32'h3, resp);
    check(resp, RESP_OKAY);
    @(posedge core_clk);
    check(rxChannelError, 1'h1);
    axiWr(8'h08, 32'h1, resp);
    check(resp, RESP_SLVERR);
    axiRd(8'h08, rd, resp);
    check(rd, 32'h0);
    check(resp, RESP_SLVERR);
    axiWr(STATUS_OFS, 32'h0, resp);
    check(resp, RESP_OKAY);
    standardPhySel <= 1'h0;
    repeat (6) @(posedge core_clk);
    axiRd(STATUS_OFS, rd, resp);
    check(rd & 32'h3, 32'h0);
    standardPhySel <= 1'h1;
    $display("Byte mode test done");
    setMode(1'h1);
    waitFlag(0);
    check({rxChannelError, rxChannelDataValid, rxChannelData}, 10'h17C);
    check({rxChannelClockSecondPhase, rxChannelClock}, 2'h2);
    axiRd(STATUS_OFS, rd, resp);
    check(rd & 32'h12, 32'h12);
    txCheck(1'h1, 1'h0, 8'h81, 10'h206);
    check(txCodeIsTenBit, 1'h1);
    mac_model_i.put(10'h000);
    waitFlag(1);
    check(rxExtraErrorFlag, 1'h1);
    waitFlag(0);
    check(rxChannelClockSecondPhase, 1'h0);
    txControlCharOrCommaEnable <= 1'h1;
    repeat (GROUP_CYCLES * 4) @(posedge core_clk);
    waitFlag(0);
    check(rxChannelClockSecondPhase, 1'h1);
    recoveredClockSel <= 1'h1;
    repeat (6) @(posedge core_clk);
    axiRd(STATUS_OFS, rd, resp);
    check(rd & 32'h16, 32'h2);
    recoveredClockSel <= 1'h0;
    $display("Ten-bit mode test done");
    final_report();
  end
endmodule
